//--- inc/acc_pkg.sv
// Purpose: Shared constants and types for the converter clocking block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Fields left at zero after reset unless stated otherwise.
package acc_pkg;
	localparam logic [7:0] IDX_RATE_DIV = 8'h02;
	localparam logic [7:0] IDX_REF_PDIV = 8'h03;
	localparam logic [7:0] IDX_PLL_J = 8'h04;
	localparam logic [7:0] IDX_FRAC_HI = 8'h05;
	localparam logic [7:0] IDX_FRAC_LO = 8'h06;
	localparam logic [7:0] IDX_PLL_R = 8'h0B;
	localparam logic [7:0] IDX_HP_EN = 8'h0C;
	localparam logic [7:0] IDX_SRC_SEL = 8'h66;
	localparam logic [7:0] IDX_HP_SEL = 8'h6B;
	localparam logic [7:0] IDX_PGA_TGT = 8'h70;
	localparam logic [7:0] IDX_ADC_CTRL = 8'h71;
	localparam logic [7:0] IDX_STATUS = 8'h72;
	localparam logic [7:0] IDX_PGA_LVL = 8'h73;
	localparam logic [7:0] IDX_COEF0 = 8'hC1;
	localparam int NUM_COEF_REGS = 6;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam int Q_LSB = 3;
	localparam int P_LSB = 0;
	localparam int J_LSB = 2;
	localparam int DLO_LSB = 2;
	localparam int SRC_DIV_LSB = 6;
	localparam int SRC_PLL_LSB = 4;
	localparam int PLL_EN_BIT = 7;
	localparam int HP_BIT = 7;
	localparam int MUTE_BIT = 7;
	localparam int CTL_PWR = 0;
	localparam int CTL_NOSOFT = 1;
	localparam int CTL_STEP2 = 2;
	localparam int CTL_DR = 3;
	localparam logic [1:0] SRC_BCLK = 2'h1;
	localparam logic [4:0] Q_WRAP = 5'h10;
	localparam logic [4:0] Q_MIN = 5'h02;
	localparam logic [3:0] NCODE_MAX = 4'hA;
	localparam logic [3:0] HALVES_BASE = 4'h2;
	localparam logic [7:0] OSR_SINGLE = 8'h80;
	localparam logic [7:0] OSR_DOUBLE = 8'h40;
	localparam logic [31:0] KFRAC_SCALE = 32'h0000_2710;
	localparam logic [31:0] PLL_DEN = 32'h0000_0008;
	localparam int HP_SHIFT = 15;
	localparam logic [6:0] GAIN_MAX = 7'h77;
	localparam logic [15:0] HP_N0_DEF = 16'h7EB8;
	localparam logic [15:0] HP_N1_DEF = 16'h8148;
	localparam logic [15:0] HP_D1_DEF = 16'h7D70;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic pll_en;
		logic [4:0] q;
		logic [3:0] p;
		logic [4:0] r;
		logic [5:0] j;
		logic [13:0] d;
		logic div_bclk;
		logic pll_bclk;
		logic [3:0] halves;
		logic dr;
	} acc_clkcfg_t;
endpackage

//--- logic/acc_core.sv
// Purpose: Converter clock generation, record decimation, gain stepping and high-pass.
// Assumes: Source clock pins are sampled levels, synchronous to mclk_i.
// Notes: One internal master tick per mclk cycle at most; faster setups saturate.
// Behaviour
// - Sample rate is reference over divider, doubled optionally.
// - Master tick runs at 256 reference rate.
// - Master tick from master clock or bit clock.
// - Divider path gives source over 128 Q.
// - Divider source chosen by select bits 7-6.
// - PLL path gives source K R over 2048 P.
// - Multiplier is integer plus ten-thousandths fraction.
// - P, R, J fields at fixed register bits.
// - Fraction split over two registers, high first.
// - PLL source chosen by select bits 5-4.
// - Modulator oversamples 128, or 64 at double rate, decimated to sample rate.
// - Decimation is linear phase, 17 samples delay.
// - Gain 0 to 59.5 dB, stepped per samples.
// - Gain mutes at reset, steps down before off.
// - Matched flag and soft-step disable bit.
// - First order high-pass with three 16-bit coefficients.
// - Coefficient select and enable bits steer filter.
module acc_core
	import acc_pkg::*;
#(
	parameter int GROUP_DELAY = 17,
	parameter int ADDR_W = 12
)
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic mclk_src_i,
	input wire logic bclk_src_i,
	input wire logic adc_bit_i,
	output logic master_tick_o,
	output logic mod_tick_o,
	output logic sample_tick_o,
	output logic [15:0] adc_data_o,
	output logic adc_valid_o,
	output logic [7:0] pga_level_o,
	output logic pga_on_o
);
	if (GROUP_DELAY < 1 || ADDR_W < 10)
	begin : g_chk
		$error("acc_core: GROUP_DELAY must be >= 1 and ADDR_W >= 10");
	end

	logic [7:0] rate_div_r, ref_pdiv_r, pll_j_r, frac_hi_r, frac_lo_r;
	logic [7:0] pll_r_r, hp_en_r, src_sel_r, hp_sel_r, pga_tgt_r, adc_ctrl_r;
	logic [7:0] coef_r [NUM_COEF_REGS];
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wlane_r, aw_have_r, w_have_r;
	logic aw_have_nxt, w_have_nxt, bvalid_nxt, rvalid_nxt, do_write;
	logic [7:0] widx, ridx, rd_val;
	logic rd_hit, wr_hit;

	// A write is committed only when both halves are held, whatever their order.
	always_comb
	begin
		aw_have_nxt = aw_have_r | (s_axi_awvalid_i & s_axi_awready_o);
		w_have_nxt = w_have_r | (s_axi_wvalid_i & s_axi_wready_o);
		do_write = aw_have_nxt & w_have_nxt & ~s_axi_bvalid_o;
		if (do_write)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
		end
		bvalid_nxt = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);
		rvalid_nxt = (s_axi_arvalid_i & s_axi_arready_o) | (s_axi_rvalid_o & ~s_axi_rready_i);
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
		end
		else
		begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			s_axi_awready_o <= ~aw_have_nxt & ~bvalid_nxt;
			s_axi_wready_o <= ~w_have_nxt & ~bvalid_nxt;
			s_axi_bvalid_o <= bvalid_nxt;
			s_axi_arready_o <= ~rvalid_nxt;
			s_axi_rvalid_o <= rvalid_nxt;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (s_axi_awvalid_i & s_axi_awready_o)
		begin
			awaddr_r <= s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i & s_axi_wready_o)
		begin
			wdata_r <= s_axi_wdata_i[7:0];
			wlane_r <= s_axi_wstrb_i[0];
		end
	end

	assign widx = (s_axi_awvalid_i & s_axi_awready_o) ? s_axi_awaddr_i[9:2] : awaddr_r[9:2];
	logic [7:0] wbyte;
	logic wlane;
	assign wbyte = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wdata_i[7:0] : wdata_r;
	assign wlane = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wstrb_i[0] : wlane_r;

	// Offsets beyond index space, or an unlisted index, answer with a slave error.
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		mapped = (a[ADDR_W-1:10] == '0) && (i == IDX_RATE_DIV || i == IDX_REF_PDIV ||
			i == IDX_PLL_J || i == IDX_FRAC_HI || i == IDX_FRAC_LO || i == IDX_PLL_R ||
			i == IDX_HP_EN || i == IDX_SRC_SEL || i == IDX_HP_SEL || i == IDX_PGA_TGT ||
			i == IDX_ADC_CTRL || i == IDX_STATUS || i == IDX_PGA_LVL ||
			(i >= IDX_COEF0 && i < IDX_COEF0 + 8'(NUM_COEF_REGS)));
	endfunction

	assign wr_hit = mapped((s_axi_awvalid_i & s_axi_awready_o) ? s_axi_awaddr_i : awaddr_r);

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			s_axi_bresp_o <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			rate_div_r <= REG_RST;
			ref_pdiv_r <= REG_RST;
			pll_j_r <= REG_RST;
			frac_hi_r <= REG_RST;
			frac_lo_r <= REG_RST;
			pll_r_r <= REG_RST;
			hp_en_r <= REG_RST;
			src_sel_r <= REG_RST;
			hp_sel_r <= REG_RST;
			pga_tgt_r <= REG_RST;
			adc_ctrl_r <= REG_RST;
		end
		else if (do_write & wlane)
		begin
			unique case (widx)
				IDX_RATE_DIV: rate_div_r <= wbyte;
				IDX_REF_PDIV: ref_pdiv_r <= wbyte;
				IDX_PLL_J: pll_j_r <= wbyte;
				IDX_FRAC_HI: frac_hi_r <= wbyte;
				IDX_FRAC_LO: frac_lo_r <= wbyte;
				IDX_PLL_R: pll_r_r <= wbyte;
				IDX_HP_EN: hp_en_r <= wbyte;
				IDX_SRC_SEL: src_sel_r <= wbyte;
				IDX_HP_SEL: hp_sel_r <= wbyte;
				IDX_PGA_TGT: pga_tgt_r <= wbyte;
				IDX_ADC_CTRL: adc_ctrl_r <= wbyte;
				default: ;
			endcase
		end
	end

	for (genvar c = 0; c < NUM_COEF_REGS; c++)
	begin : g_coef
		always_ff @(posedge mclk_i)
		begin
			if (reset_i)
			begin
				coef_r[c] <= REG_RST;
			end
			else if (do_write & wlane & (widx == IDX_COEF0 + 8'(c)))
			begin
				coef_r[c] <= wbyte;
			end
		end
	end

	logic [7:0] level_r, target;
	logic matched, pd_busy;

	assign ridx = s_axi_araddr_i[9:2];
	assign rd_hit = mapped(s_axi_araddr_i);

	always_comb
	begin
		rd_val = REG_RST;
		if (ridx >= IDX_COEF0 && ridx < IDX_COEF0 + 8'(NUM_COEF_REGS))
		begin
			rd_val = coef_r[3'(ridx - IDX_COEF0)];
		end
		else
		begin
			unique case (ridx)
				IDX_RATE_DIV: rd_val = rate_div_r;
				IDX_REF_PDIV: rd_val = ref_pdiv_r;
				IDX_PLL_J: rd_val = pll_j_r;
				IDX_FRAC_HI: rd_val = frac_hi_r;
				IDX_FRAC_LO: rd_val = frac_lo_r;
				IDX_PLL_R: rd_val = pll_r_r;
				IDX_HP_EN: rd_val = hp_en_r;
				IDX_SRC_SEL: rd_val = src_sel_r;
				IDX_HP_SEL: rd_val = hp_sel_r;
				IDX_PGA_TGT: rd_val = pga_tgt_r;
				IDX_ADC_CTRL: rd_val = adc_ctrl_r;
				IDX_STATUS: rd_val = {5'h00, pga_on_o, pd_busy, matched};
				IDX_PGA_LVL: rd_val = level_r;
				default: rd_val = REG_RST;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i & s_axi_arready_o)
		begin
			s_axi_rdata_o <= {24'h00_0000, rd_hit ? rd_val : REG_RST};
			s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Decoded clock setup; zero P and R codes wrap to the top of their ranges, Q codes 0 and 1 wrap to 16 and 17, J does not wrap.
	acc_clkcfg_t cfg;
	logic [3:0] ncode;
	always_comb
	begin
		cfg.pll_en = ref_pdiv_r[PLL_EN_BIT];
		cfg.q = {1'b0, ref_pdiv_r[Q_LSB +: 4]};
		if (cfg.q < Q_MIN)
		begin
			cfg.q = cfg.q + Q_WRAP;
		end
		cfg.p = (ref_pdiv_r[P_LSB +: 3] == 3'h0) ? 4'h8 : {1'b0, ref_pdiv_r[P_LSB +: 3]};
		cfg.r = (pll_r_r[3:0] == 4'h0) ? 5'h10 : {1'b0, pll_r_r[3:0]};
		cfg.j = pll_j_r[J_LSB +: 6];
		cfg.d = {frac_hi_r, frac_lo_r[DLO_LSB +: 6]};
		cfg.div_bclk = src_sel_r[SRC_DIV_LSB +: 2] == SRC_BCLK;
		cfg.pll_bclk = src_sel_r[SRC_PLL_LSB +: 2] == SRC_BCLK;
		// The record nibble drives the common rate; the playback nibble must match it.
		ncode = (rate_div_r[3:0] > NCODE_MAX) ? NCODE_MAX : rate_div_r[3:0];
		cfg.halves = ncode + HALVES_BASE;
		cfg.dr = adc_ctrl_r[CTL_DR];
	end

	logic mclk_prev_r, bclk_prev_r;
	logic [4:0] qcnt_r;
	logic [31:0] acc_r, pll_inc, pll_mod, kval;
	logic div_src, div_prev, pll_src, pll_prev, tick;

	always_ff @(posedge mclk_i)
	begin
		mclk_prev_r <= mclk_src_i;
		bclk_prev_r <= bclk_src_i;
	end

	assign div_src = cfg.div_bclk ? bclk_src_i : mclk_src_i;
	assign div_prev = cfg.div_bclk ? bclk_prev_r : mclk_prev_r;
	assign pll_src = cfg.pll_bclk ? bclk_src_i : mclk_src_i;
	assign pll_prev = cfg.pll_bclk ? bclk_prev_r : mclk_prev_r;
	// Master rate is source times K R over 8 P, i.e. 256 times the reference rate.
	assign kval = 32'(cfg.j) * KFRAC_SCALE + 32'(cfg.d);
	assign pll_inc = 32'(kval * 32'(cfg.r));
	assign pll_mod = 32'(PLL_DEN * 32'(cfg.p) * KFRAC_SCALE);

	// Both edges are counted so that Q source edges give 256 ticks per 128 Q periods.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i | cfg.pll_en)
		begin
			qcnt_r <= 5'h00;
		end
		else if (div_src != div_prev)
		begin
			qcnt_r <= (qcnt_r + 5'h01 >= cfg.q) ? 5'h00 : qcnt_r + 5'h01;
		end
	end

	// Fractional synthesis as a phase accumulator; adds pause while a tick is pending.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i | ~cfg.pll_en)
		begin
			acc_r <= 32'h0000_0000;
		end
		else
		begin
			acc_r <= acc_r + ((pll_src & ~pll_prev & acc_r < pll_mod) ? pll_inc : 32'h0000_0000)
				- ((acc_r >= pll_mod) ? pll_mod : 32'h0000_0000);
		end
	end

	always_comb
	begin
		if (cfg.pll_en)
		begin
			tick = acc_r >= pll_mod;
		end
		else
		begin
			tick = (div_src != div_prev) && (qcnt_r + 5'h01 >= cfg.q);
		end
	end

	logic [3:0] hcnt_r;
	logic [7:0] ocnt_r, osr, ones_r, ones_nxt;
	logic mtick, stick;

	assign osr = cfg.dr ? OSR_DOUBLE : OSR_SINGLE;
	assign mtick = tick && (hcnt_r + 4'h1 >= cfg.halves);
	assign stick = mtick && (ocnt_r + 8'h01 >= osr);
	assign ones_nxt = ones_r + {7'h00, adc_bit_i};

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			hcnt_r <= 4'h0;
			ocnt_r <= 8'h00;
			ones_r <= 8'h00;
			master_tick_o <= 1'b0;
			mod_tick_o <= 1'b0;
			sample_tick_o <= 1'b0;
		end
		else
		begin
			master_tick_o <= tick;
			mod_tick_o <= mtick;
			sample_tick_o <= stick;
			if (tick)
			begin
				hcnt_r <= mtick ? 4'h0 : hcnt_r + 4'h1;
			end
			if (mtick)
			begin
				ocnt_r <= stick ? 8'h00 : ocnt_r + 8'h01;
				ones_r <= stick ? 8'h00 : ones_nxt;
			end
		end
	end

	// Boxcar over one output period, then a pure delay: linear phase by construction.
	logic [16:0] scaled;
	logic [15:0] box;
	logic [15:0] dline_r [GROUP_DELAY];
	assign scaled = (17'(ones_nxt) << (cfg.dr ? 10 : 9)) - 17'h0_8000;
	assign box = (scaled[16] == 1'b0 && scaled[15]) ? 16'h7FFF : scaled[15:0];

	for (genvar k = 0; k < GROUP_DELAY; k++)
	begin : g_dly
		always_ff @(posedge mclk_i)
		begin
			if (reset_i)
			begin
				dline_r[k] <= 16'h0000;
			end
			else if (stick)
			begin
				dline_r[k] <= (k == 0) ? box : dline_r[(k == 0) ? 0 : k - 1];
			end
		end
	end

	logic signed [15:0] hx, hx_prev_r, hy_prev_r, hn0, hn1, hd1, hy;
	logic signed [33:0] hsum, hq;
	assign hx = dline_r[GROUP_DELAY-1];
	assign hn0 = hp_sel_r[HP_BIT] ? {coef_r[0], coef_r[1]} : HP_N0_DEF;
	assign hn1 = hp_sel_r[HP_BIT] ? {coef_r[2], coef_r[3]} : HP_N1_DEF;
	assign hd1 = hp_sel_r[HP_BIT] ? {coef_r[4], coef_r[5]} : HP_D1_DEF;
	assign hsum = 34'(hn0 * hx) + 34'(hn1 * hx_prev_r) + 34'(hd1 * hy_prev_r);
	assign hq = hsum >>> HP_SHIFT;

	always_comb
	begin
		if (!hp_en_r[HP_BIT])
		begin
			hy = hx;
		end
		else if (hq > 34'sh0_7FFF)
		begin
			hy = 16'sh7FFF;
		end
		else if (hq < -34'sh0_8000)
		begin
			hy = -16'sh8000;
		end
		else
		begin
			hy = hq[15:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			hx_prev_r <= 16'sh0000;
			hy_prev_r <= 16'sh0000;
			adc_data_o <= 16'h0000;
			adc_valid_o <= 1'b0;
		end
		else
		begin
			adc_valid_o <= stick;
			if (stick)
			begin
				hx_prev_r <= hx;
				hy_prev_r <= hy;
				adc_data_o <= hy;
			end
		end
	end

	// Level 0 is mute; level n is (n-1) half-dB steps of gain.
	logic phase_r;
	logic [6:0] tgain;
	assign tgain = (pga_tgt_r[6:0] > GAIN_MAX) ? GAIN_MAX : pga_tgt_r[6:0];
	assign target = (adc_ctrl_r[CTL_PWR] & ~pga_tgt_r[MUTE_BIT]) ? {1'b0, tgain} + 8'h01 : 8'h00;
	assign matched = level_r == target;
	// Busy while power is off but the gain has not yet reached mute.
	assign pd_busy = ~adc_ctrl_r[CTL_PWR] & (level_r != 8'h00);

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			level_r <= 8'h00;
			phase_r <= 1'b0;
		end
		else if (adc_ctrl_r[CTL_NOSOFT])
		begin
			level_r <= target;
			phase_r <= 1'b0;
		end
		else if (stick && !matched)
		begin
			phase_r <= adc_ctrl_r[CTL_STEP2] & ~phase_r;
			if (!adc_ctrl_r[CTL_STEP2] || phase_r)
			begin
				level_r <= (level_r < target) ? level_r + 8'h01 : level_r - 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			pga_level_o <= 8'h00;
			pga_on_o <= 1'b0;
		end
		else
		begin
			pga_level_o <= level_r;
			// The amplifier stays on until the down-step reaches mute.
			pga_on_o <= adc_ctrl_r[CTL_PWR] | (level_r != 8'h00);
		end
	end
endmodule

//--- sim/acc_core_props.sv
// Purpose: Port-level assertions for the converter clocking block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Register contents are unseen here, so the gain checks stay coarse.
module acc_core_props
	import acc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic master_tick_o,
	input wire logic mod_tick_o,
	input wire logic sample_tick_o,
	input wire logic adc_valid_o,
	input wire logic [15:0] adc_data_o,
	input wire logic [7:0] pga_level_o,
	input wire logic pga_on_o
);
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	a_mod_on_master: assert property (mod_tick_o |-> master_tick_o)
		else $error("mod tick alone");
	a_mod_spacing: assert property (mod_tick_o |=> !mod_tick_o)
		else $error("mod ticks adjacent");
	a_sample_on_mod: assert property (sample_tick_o |-> mod_tick_o)
		else $error("sample tick alone");
	a_sample_gap: assert property (sample_tick_o |=> !sample_tick_o [*8])
		else $error("sample ticks too close");
	a_valid_on_sample: assert property (adc_valid_o |-> sample_tick_o)
		else $error("valid off sample tick");
	a_data_steady: assert property (!adc_valid_o |-> $stable(adc_data_o))
		else $error("sample data changed without valid");
	a_gain_ceiling: assert property (pga_level_o <= 8'h78)
		else $error("gain above range");
	a_off_is_mute: assert property (!pga_on_o |-> pga_level_o == 8'h00)
		else $error("gain while off");
	a_reset_mute: assert property ($fell(reset_i) |-> !pga_on_o && pga_level_o == 8'h00)
		else $error("gain not muted at reset");
	a_read_answer: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h00_0000)
		else $error("read answer late or wide");
endmodule

bind acc_core acc_core_props props_u (
	.mclk_i(mclk_i),
	.reset_i(reset_i),
	.s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o),
	.master_tick_o(master_tick_o),
	.mod_tick_o(mod_tick_o),
	.sample_tick_o(sample_tick_o),
	.adc_valid_o(adc_valid_o),
	.adc_data_o(adc_data_o),
	.pga_level_o(pga_level_o),
	.pga_on_o(pga_on_o)
);

//--- sim/acc_src_model.sv
// Purpose: Far-side model: master and bit clock sources plus the modulator bit.
// Assumes: Sources are levels sampled on mclk_i, as the block expects.
// Notes: Half periods are in mclk_i cycles and must stay at two or more.
module acc_src_model
#(
	parameter int M_HALF = 2,
	parameter int B_HALF = 3
)
(
	input wire logic mclk_i,
	input wire logic ones_i,
	output logic mclk_src_o,
	output logic bclk_src_o,
	output logic adc_bit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int m_cnt = 0;
	int b_cnt = 0;
	logic m_lvl_r = 1'b0;
	logic b_lvl_r = 1'b0;
	assign mclk_src_o = m_lvl_r;
	assign bclk_src_o = b_lvl_r;
	// Both sources run free, so a soft-step down to mute can always finish.
	always @(posedge mclk_i)
	begin
		m_cnt <= (m_cnt == M_HALF - 1) ? 0 : m_cnt + 1;
		b_cnt <= (b_cnt == B_HALF - 1) ? 0 : b_cnt + 1;
		if (m_cnt == M_HALF - 1) m_lvl_r <= ~m_lvl_r;
		if (b_cnt == B_HALF - 1) b_lvl_r <= ~b_lvl_r;
	end
	assign adc_bit_o = ones_i;
endmodule

//--- sim/tb.sv
// Purpose: Self-checking bench for the converter clocking block.
// Assumes: Register index n sits at byte address four times n.
// Notes: Rate checks count ticks in windows, so they allow two ticks of slack.
module tb
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] val;
		logic [7:0] back;
		logic [1:0] resp;
	} acc_row_t;
	localparam acc_row_t ROWS [11] = '{
		'{IDX_RATE_DIV, 8'h33, 8'h33, RESP_OKAY},
		'{IDX_REF_PDIV, 8'h10, 8'h10, RESP_OKAY},
		'{IDX_PLL_J, 8'h24, 8'h24, RESP_OKAY},
		'{IDX_FRAC_HI, 8'h4E, 8'h4E, RESP_OKAY},
		'{IDX_FRAC_LO, 8'h20, 8'h20, RESP_OKAY},
		'{IDX_PLL_R, 8'h01, 8'h01, RESP_OKAY},
		'{IDX_SRC_SEL, 8'h40, 8'h40, RESP_OKAY},
		'{IDX_HP_SEL, 8'h80, 8'h80, RESP_OKAY},
		'{IDX_COEF0, 8'h40, 8'h40, RESP_OKAY},
		'{IDX_PGA_LVL, 8'h55, 8'h00, RESP_OKAY},
		'{8'h07, 8'h5A, 8'h00, RESP_SLVERR}};
	// Code 3 is a half step, run only with an even reference divider.
	localparam logic [3:0] CODES [4] = '{4'h0, 4'h3, 4'hA, 4'hC};
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [11:0] s_axi_awaddr_i = 12'h000;
	logic [11:0] s_axi_araddr_i = 12'h000;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000;
	logic [3:0] s_axi_wstrb_i = 4'h1;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, ones = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r, rr;
	logic [31:0] s_axi_rdata_o, v;
	logic mclk_src_i, bclk_src_i, adc_bit_i, pga_on_o;
	logic master_tick_o, mod_tick_o, sample_tick_o, adc_valid_o;
	logic [15:0] adc_data_o, old;
	logic [7:0] pga_level_o, lv;
	logic [3:0] ticks;
	int n_mismatch = 0;
	int checked = 0;
	int g, n, k;
	assign ticks = {adc_valid_o, sample_tick_o, mod_tick_o, master_tick_o};
	always #4 mclk_i = ~mclk_i;
	acc_core dut_u (.*);
	acc_src_model src_u (.mclk_i, .ones_i(ones), .mclk_src_o(mclk_src_i),
		.bclk_src_o(bclk_src_i), .adc_bit_o(adc_bit_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic near(input int c, input int exp);
		check((c >= exp - 2 && c <= exp + 2) ? exp : c, exp);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		@(posedge mclk_i);
		s_axi_awaddr_i <= {2'h0, idx, 2'h0};
		s_axi_wdata_i <= {24'h00_0000, val};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end
		while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		r = s_axi_bresp_o;
	endtask

	task automatic rd(input logic [7:0] idx);
		@(posedge mclk_i);
		s_axi_araddr_i <= {2'h0, idx, 2'h0};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end
		while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		v = s_axi_rdata_o;
		rr = s_axi_rresp_o;
	endtask

	task automatic wait_tick(input int sel, output int gap);
		gap = 0;
		do
		begin
			@(posedge mclk_i);
			#1;
			gap++;
		end
		while (ticks[sel] !== 1'b1 && gap < 2000);
	endtask

	task automatic period(input int sel, output int gap);
		repeat (3) wait_tick(sel, gap);
	endtask

	task automatic count(input int sel, input int cyc, output int c);
		c = 0;
		repeat (cyc)
		begin
			@(posedge mclk_i);
			#1;
			c += (ticks[sel] === 1'b1);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge mclk_i);
		n_mismatch++;
		stop_test;
	end

	initial
	begin
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		foreach (ROWS[i])
		begin
			rd(ROWS[i].idx);
			check(v, 32'h0000_0000);
			wr(ROWS[i].idx, ROWS[i].val);
			check(32'(r), 32'(ROWS[i].resp));
			rd(ROWS[i].idx);
			check(v, {24'h00_0000, ROWS[i].back});
			check(32'(rr), 32'(ROWS[i].resp));
		end
		// Both source clocks change level every few cycles; Q of two takes two edges.
		count(0, 600, n);
		near(n, 100);
		wr(IDX_SRC_SEL, 8'h00);
		count(0, 600, n);
		near(n, 150);
		wr(IDX_REF_PDIV, 8'h08);
		count(0, 680, n);
		near(n, 20);
		// Multiplier 9.5 with R of one keeps the synthesiser in its fractional range.
		wr(IDX_REF_PDIV, 8'h81);
		count(0, 800, n);
		near(n, 237);
		wr(IDX_REF_PDIV, 8'h82);
		count(0, 800, n);
		near(n, 119);
		wr(IDX_SRC_SEL, 8'h10);
		wr(IDX_REF_PDIV, 8'h81);
		count(0, 800, n);
		near(n, 158);
		wr(IDX_REF_PDIV, 8'h10);
		wr(IDX_SRC_SEL, 8'h00);
		wr(IDX_ADC_CTRL, 8'h01);
		foreach (CODES[i])
		begin
			wr(IDX_RATE_DIV, {CODES[i], CODES[i]});
			period(1, g);
			check(g, 4 * (2 + ((CODES[i] > NCODE_MAX) ? NCODE_MAX : CODES[i])));
		end
		wr(IDX_RATE_DIV, 8'h00);
		period(2, g);
		check(g, 1024);
		wr(IDX_ADC_CTRL, 8'h09);
		period(2, g);
		check(g, 512);
		repeat (20) wait_tick(3, g);
		old = adc_data_o;
		@(posedge mclk_i);
		ones <= 1'b1;
		k = 0;
		do
		begin
			wait_tick(3, g);
			k++;
		end
		while (adc_data_o === old && k < 40);
		check((k == 17 || k == 18) ? 18 : k, 18);
		repeat (2) wait_tick(3, g);
		check(32'(adc_data_o), 32'h0000_7FFF);
		wr(IDX_HP_EN, 8'h80);
		repeat (3) wait_tick(3, g);
		check(32'(adc_data_o), 32'h0000_3FFF);
		wr(IDX_HP_SEL, 8'h00);
		wait_tick(3, g);
		check(32'(adc_data_o), 32'h0000_3EB7);
		wr(IDX_PGA_TGT, 8'h04);
		rd(IDX_STATUS);
		check(v & 32'h0000_0001, 32'h0000_0000);
		wait_tick(2, g);
		lv = pga_level_o;
		wait_tick(2, g);
		check(32'(pga_level_o), 32'(lv + 8'h01));
		repeat (6) wait_tick(2, g);
		check(32'(pga_level_o), 32'h0000_0005);
		rd(IDX_STATUS);
		check(v & 32'h0000_0005, 32'h0000_0005);
		wr(IDX_ADC_CTRL, 8'h0D);
		wr(IDX_PGA_TGT, 8'h06);
		wait_tick(2, g);
		lv = pga_level_o;
		repeat (2) wait_tick(2, g);
		check(32'(pga_level_o), 32'(lv + 8'h01));
		wr(IDX_ADC_CTRL, 8'h0B);
		wr(IDX_PGA_TGT, 8'h77);
		repeat (4) @(posedge mclk_i);
		check(32'(pga_level_o), 32'h0000_0078);
		wr(IDX_PGA_TGT, 8'h02);
		wr(IDX_ADC_CTRL, 8'h08);
		rd(IDX_STATUS);
		check(v & 32'h0000_0006, 32'h0000_0006);
		repeat (5) wait_tick(2, g);
		check(32'({pga_on_o, pga_level_o}), 32'h0000_0000);
		rd(IDX_STATUS);
		check(v & 32'h0000_0006, 32'h0000_0000);
		// A live gain before the reset below, so that its return to mute is really seen.
		wr(IDX_ADC_CTRL, 8'h03);
		wr(IDX_PGA_TGT, 8'h90);
		repeat (2) @(posedge mclk_i);
		check(32'({pga_on_o, pga_level_o}), 32'h0000_0100);
		wr(IDX_PGA_TGT, 8'h10);
		repeat (2) @(posedge mclk_i);
		check(32'(pga_level_o), 32'h0000_0011);
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		check(32'({pga_on_o, pga_level_o}), 32'h0000_0000);
		rd(IDX_PLL_J);
		check(v, 32'h0000_0000);
		// A write with its low lane disabled is answered but must not store.
		s_axi_wstrb_i <= 4'h0;
		wr(IDX_PLL_J, 8'hFC);
		check(32'(r), 32'(RESP_OKAY));
		rd(IDX_PLL_J);
		check(v, 32'h0000_0000);
		stop_test;
	end
endmodule
